/* File: lii_pkg.sv */
/*
 Constants, types and helper functions for the indicator latch logic.
 Assumes a 20 MHz system clock and an AXI4-Lite register bus.
*/
package lii_pkg;

   localparam int NUM_LED = 8;
   localparam int NUM_SLOT = 5;
   localparam int NUM_TRIG = 15;
   localparam int SEL_W = 4;
   localparam int NUM_PIN = NUM_TRIG + NUM_LED + 5;

   // Register map, byte addresses
   localparam logic [31:0] CFG_BASE = 32'h0000_0000;
   localparam logic [31:0] APP_BASE = 32'h0000_0020;
   localparam logic [31:0] CTRL_ADDR = 32'h0000_0040;
   localparam logic [31:0] STAT_ADDR = 32'h0000_0044;
   localparam logic [31:0] TRIG_ADDR = 32'h0000_0048;

   // Control bits
   localparam int CTRL_REMOTE_EN_BIT = 0;
   localparam int CTRL_REMOTE_ACK_BIT = 1;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;

   // Status fields
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_LATCH_LSB = 8;
   localparam int STAT_BOOT_BIT = 16;
   localparam int STAT_RELAY_BIT = 17;

   // Latch modes
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_LATCH = 2'h1;
   localparam logic [1:0] MODE_LATCH_ALARM = 2'h2;

   // Appearances
   localparam logic [2:0] APP_OFF = 3'h0;
   localparam logic [2:0] APP_GREEN = 3'h1;
   localparam logic [2:0] APP_RED = 3'h2;
   localparam logic [2:0] APP_RED_FLASH = 3'h3;
   localparam logic [2:0] APP_GREEN_FLASH = 3'h4;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Flash timing
   localparam int CLK_KHZ = 20000;
   localparam int FLASH_HALF_MS = 250;
   localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CLK_KHZ;

   typedef struct packed {
      logic [4:0] rsvd;
      logic [1:0] mode;
      logic [NUM_SLOT-1:0] inv;
      logic [NUM_SLOT-1:0][SEL_W-1:0] sel;
   } lii_cfg_t;

   typedef struct packed {
      logic [25:0] rsvd;
      logic [2:0] idle;
      logic [2:0] asserted;
   } lii_app_t;

   localparam logic [31:0] CFG_MASK = 32'h07ff_ffff;
   localparam logic [31:0] APP_MASK = 32'h0000_003f;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0001;

   function automatic logic slot_val(input logic [SEL_W-1:0] sel, input logic inv,
                                     input logic [NUM_TRIG-1:0] trig);
      if (sel == '0) begin
         return 1'b0;
      end
      return trig[sel - 4'h1] ^ inv;
   endfunction

   function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return res;
   endfunction

endpackage

/* File: lii_blink.sv */
/*
 Free-running flash phase generator.
 Assumes the system clock; the half period is a parameter so benches can shorten it.
*/
module lii_blink
   import lii_pkg::*;
#(
   parameter int HALF_CYC = FLASH_HALF_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Phase
   output logic phase
);

   logic [31:0] cnt_ff;
   logic phase_ff;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= 32'h0;
      end else if (cnt_ff >= 32'(HALF_CYC - 1)) begin
         cnt_ff <= 32'h0;
      end else begin
         cnt_ff <= cnt_ff + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phase_ff <= 1'b0;
      end else if (cnt_ff >= 32'(HALF_CYC - 1)) begin
         phase_ff <= ~phase_ff;
      end
   end

   assign phase = phase_ff;

endmodule

/* File: lii_indicator.sv */
/*
 One configurable indicator: slot combine, latch and colour drive.
 Assumes synchronised triggers and one-cycle acknowledge pulses.
*/
module lii_indicator
   import lii_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Configuration
   input wire lii_cfg_t cfg,
   input wire lii_app_t app,
   // Inputs
   input wire logic [NUM_TRIG-1:0] trig,
   input wire logic blink,
   input wire logic ack_local,
   input wire logic ack_group,
   input wire logic alarm,
   // Outputs
   output logic red,
   output logic green,
   output logic state,
   output logic latched
);

   logic [NUM_SLOT-1:0] slot;
   logic [NUM_SLOT-1:0] assigned;
   logic active;
   logic latch_on;
   logic ack_any;
   logic latched_ff;
   logic red_ff;
   logic green_ff;
   logic [2:0] shown;

   for (genvar s = 0; s < NUM_SLOT; s++) begin : g_slot
      assign slot[s] = slot_val(cfg.sel[s], cfg.inv[s], trig);
      assign assigned[s] = (cfg.sel[s] != '0);
   end

   assign active = |slot;
   assign latch_on = (cfg.mode == MODE_LATCH) || (cfg.mode == MODE_LATCH_ALARM);
   assign ack_any = ack_local || ack_group ||
                    (alarm && cfg.mode == MODE_LATCH_ALARM);

   // Reset only at power-on, so firmware restarts keep the held state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         latched_ff <= 1'b0;
      end else if (!latch_on || assigned == '0) begin
         latched_ff <= 1'b0;
      end else if (active) begin
         latched_ff <= 1'b1;
      end else if (ack_any) begin
         latched_ff <= 1'b0;
      end
   end

   assign state = active || (latch_on && latched_ff);
   assign latched = latched_ff;
   assign shown = state ? app.asserted : app.idle;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         red_ff <= 1'b0;
         green_ff <= 1'b0;
      end else begin
         unique case (shown)
            APP_GREEN: begin
               red_ff <= 1'b0;
               green_ff <= 1'b1;
            end
            APP_RED: begin
               red_ff <= 1'b1;
               green_ff <= 1'b0;
            end
            APP_RED_FLASH: begin
               red_ff <= blink;
               green_ff <= 1'b0;
            end
            APP_GREEN_FLASH: begin
               red_ff <= 1'b0;
               green_ff <= blink;
            end
            default: begin
               red_ff <= 1'b0;
               green_ff <= 1'b0;
            end
         endcase
      end
   end

   assign red = red_ff;
   assign green = green_ff;

endmodule

/* File: lii_top.sv */
/*
 Front-panel indicator logic with AXI4-Lite register access.
 Assumes pins are asynchronous to clk; rst_b is the power-on reset only.
*/
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
module lii_top
   import lii_pkg::*;
#(
   parameter int FLASH_HALF = FLASH_HALF_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // AXI4-Lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] awaddr,
   input wire logic [2:0] awprot,
   // AXI4-Lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [31:0] araddr,
   input wire logic [2:0] arprot,
   // AXI4-Lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Trigger and acknowledge pins
   input wire logic [NUM_TRIG-1:0] trig_pin,
   input wire logic [NUM_LED-1:0] led_ack_pin,
   input wire logic clear_key_pin,
   input wire logic global_indicator_clear_input,
   input wire logic prot_alarm_pin,
   // Device health pins
   input wire logic boot_done_pin,
   input wire logic int_fault_pin,
   // Indicator outputs
   output logic [NUM_LED-1:0] led_red,
   output logic [NUM_LED-1:0] led_green,
   output logic health_green,
   output logic self_supervision_relay
);

   // Pin synchronisers
   logic [NUM_PIN-1:0] pin_raw;
   logic [NUM_PIN-1:0] sync1_ff;
   logic [NUM_PIN-1:0] sync2_ff;
   logic [NUM_PIN-1:0] prev_ff;
   logic [NUM_PIN-1:0] rise;

   // Register state
   lii_cfg_t cfg_ff [NUM_LED];
   lii_app_t app_ff [NUM_LED];
   logic [31:0] ctrl_ff;
   logic remote_ack_ff;

   // Bus state
   logic aw_hold_ff;
   logic [31:0] awaddr_ff;
   logic w_hold_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic wr_go;
   logic [31:0] nxt_rdata;
   logic nxt_rok;

   // Indicator and health
   logic [NUM_TRIG-1:0] trig_s;
   logic [NUM_LED-1:0] led_ack_p;
   logic key_p;
   logic glob_p;
   logic alarm_p;
   logic boot_s;
   logic fault_s;
   logic ack_group;
   logic blink;
   logic [NUM_LED-1:0] led_state;
   logic [NUM_LED-1:0] led_latched;
   logic health_ff;
   logic relay_ff;

   // Register decode, shared by read and write paths
   function automatic logic addr_hit(input logic [31:0] a);
      return (a[31:7] == 25'h0 && a[1:0] == 2'h0) &&
             (a < CTRL_ADDR || a == CTRL_ADDR || a == STAT_ADDR || a == TRIG_ADDR);
   endfunction

   assign pin_raw = {int_fault_pin, boot_done_pin, prot_alarm_pin,
                     global_indicator_clear_input, clear_key_pin, led_ack_pin, trig_pin};

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         prev_ff <= '0;
      end else begin
         sync1_ff <= pin_raw;
         sync2_ff <= sync1_ff;
         prev_ff <= sync2_ff;
      end
   end

   // Edges turn held buttons into single requests
   assign rise = sync2_ff & ~prev_ff;
   assign trig_s = sync2_ff[NUM_TRIG-1:0];
   assign led_ack_p = rise[NUM_TRIG +: NUM_LED];
   assign key_p = rise[NUM_TRIG+NUM_LED];
   assign glob_p = rise[NUM_TRIG+NUM_LED+1];
   assign alarm_p = rise[NUM_TRIG+NUM_LED+2];
   assign boot_s = sync2_ff[NUM_TRIG+NUM_LED+3];
   assign fault_s = sync2_ff[NUM_TRIG+NUM_LED+4];

   // Clear key always acts; input and remote need permission
   assign ack_group = key_p ||
                      (ctrl_ff[CTRL_REMOTE_EN_BIT] && (glob_p || remote_ack_ff));

   // Write channel
   assign awready = !aw_hold_ff && !bvalid_ff;
   assign wready = !w_hold_ff && !bvalid_ff;
   assign wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_hold_ff <= 1'b0;
         awaddr_ff <= 32'h0;
      end else if (awvalid && awready) begin
         aw_hold_ff <= 1'b1;
         awaddr_ff <= awaddr;
      end else if (wr_go) begin
         aw_hold_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         w_hold_ff <= 1'b0;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
      end else if (wvalid && wready) begin
         w_hold_ff <= 1'b1;
         wdata_ff <= wdata;
         wstrb_ff <= wstrb;
      end else if (wr_go) begin
         w_hold_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= addr_hit(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // Configuration registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NUM_LED; i++) begin
            cfg_ff[i] <= '0;
            app_ff[i] <= '0;
         end
      end else if (wr_go && awaddr_ff[31:6] == 26'h0) begin
         for (int i = 0; i < NUM_LED; i++) begin
            if (awaddr_ff == CFG_BASE + 32'(4 * i)) begin
               cfg_ff[i] <= apply_strb(cfg_ff[i], wdata_ff, wstrb_ff) & CFG_MASK;
            end
            if (awaddr_ff == APP_BASE + 32'(4 * i)) begin
               app_ff[i] <= apply_strb(app_ff[i], wdata_ff, wstrb_ff) & APP_MASK;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_ff <= CTRL_RST;
      end else if (wr_go && awaddr_ff == CTRL_ADDR) begin
         ctrl_ff <= apply_strb(ctrl_ff, wdata_ff, wstrb_ff) & CTRL_MASK;
      end
   end

   // Writing one to the remote bit gives a single acknowledge pulse
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         remote_ack_ff <= 1'b0;
      end else begin
         remote_ack_ff <= wr_go && awaddr_ff == CTRL_ADDR && wstrb_ff[0] &&
                          wdata_ff[CTRL_REMOTE_ACK_BIT];
      end
   end

   // Read channel
   assign arready = !rvalid_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;

   always_comb begin
      nxt_rdata = 32'h0;
      nxt_rok = addr_hit(araddr);
      for (int i = 0; i < NUM_LED; i++) begin
         if (araddr == CFG_BASE + 32'(4 * i)) begin
            nxt_rdata = cfg_ff[i];
         end
         if (araddr == APP_BASE + 32'(4 * i)) begin
            nxt_rdata = app_ff[i];
         end
      end
      if (araddr == CTRL_ADDR) begin
         nxt_rdata = ctrl_ff;
      end
      if (araddr == STAT_ADDR) begin
         nxt_rdata[STAT_STATE_LSB +: NUM_LED] = led_state;
         nxt_rdata[STAT_LATCH_LSB +: NUM_LED] = led_latched;
         nxt_rdata[STAT_BOOT_BIT] = boot_s;
         nxt_rdata[STAT_RELAY_BIT] = relay_ff;
      end
      if (araddr == TRIG_ADDR) begin
         nxt_rdata[NUM_TRIG-1:0] = trig_s;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0;
         rresp_ff <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rok ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   // Flash source shared by all indicators
   lii_blink #(
      .HALF_CYC(FLASH_HALF)
   ) u_blink (
      .clk(clk),
      .rst_b(rst_b),
      .phase(blink)
   );

   for (genvar i = 0; i < NUM_LED; i++) begin : g_led
      lii_indicator u_ind (
         .clk(clk),
         .rst_b(rst_b),
         .cfg(cfg_ff[i]),
         .app(app_ff[i]),
         .trig(trig_s),
         .blink(blink),
         .ack_local(led_ack_p[i]),
         .ack_group(ack_group),
         .alarm(alarm_p),
         .red(led_red[i]),
         .green(led_green[i]),
         .state(led_state[i]),
         .latched(led_latched[i])
      );
   end

   // Health indicator and supervision relay
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         health_ff <= 1'b0;
      end else begin
         health_ff <= boot_s ? 1'b1 : blink;
      end
   end

   // Relay drops on any fault so a dead device fails safe
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         relay_ff <= 1'b0;
      end else begin
         relay_ff <= boot_s && !fault_s;
      end
   end

   assign health_green = health_ff;
   assign self_supervision_relay = relay_ff;

endmodule

/* File: lii_top_asserts.sv */
/*
 Checker for lii_top: bus handshakes, colour and health outputs.
 Assumes it is bound to lii_top and sees only its ports.
*/
module lii_top_asserts
   import lii_pkg::*;
#(
   parameter int FLASH_HALF = FLASH_HALF_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   // Health and indicators
   input wire logic boot_done_pin,
   input wire logic int_fault_pin,
   input wire logic [NUM_LED-1:0] led_red,
   input wire logic [NUM_LED-1:0] led_green,
   input wire logic health_green,
   input wire logic self_supervision_relay
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped early");
   chk_ar_block: assert property (rvalid && rready |=> !rvalid && arready)
      else $error("read answer repeated or read channel stuck");
   chk_aw_block: assert property (bvalid && bready |=> !bvalid && awready && wready)
      else $error("write answer repeated or write channel stuck");
   chk_rd_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   chk_wr_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write answer late");
   chk_one_colour: assert property ((led_red & led_green) == 8'h0)
      else $error("indicator lit in two colours");
   chk_relay_fault: assert property (int_fault_pin [*4] |-> !self_supervision_relay)
      else $error("relay energised with fault");
   chk_relay_boot: assert property (!boot_done_pin [*4] |-> !self_supervision_relay)
      else $error("relay energised during boot");
   chk_relay_on: assert property ((boot_done_pin && !int_fault_pin) [*5]
      |-> self_supervision_relay)
      else $error("relay not energised");
   chk_health_on: assert property (boot_done_pin [*5] |-> health_green)
      else $error("health not steady after boot");
endmodule

bind lii_top lii_top_asserts #(.FLASH_HALF(FLASH_HALF)) u_lii_top_asserts (
   .clk(clk), .rst_b(rst_b), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
   .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
   .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
   .boot_done_pin(boot_done_pin), .int_fault_pin(int_fault_pin), .led_red(led_red),
   .led_green(led_green), .health_green(health_green),
   .self_supervision_relay(self_supervision_relay));

/* File: led_indicator_latch_logic_bench.sv */
/*
 Self-checking bench for lii_top with a model of the indicators.
 Assumes lii_pkg and the design are compiled first.
*/
module led_indicator_latch_logic_bench
   import lii_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [1:0] bresp, rresp;
   logic [14:0] trig_pin;
   logic [10:0] ackv;
   logic boot, fault, health_green, relay;
   logic [7:0] led_red, led_green, mlat;
   logic [31:0] mcfg [8];
   logic [31:0] mapp [8];
   logic [31:0] seed = 32'h2a73;
   int mismatches = 0;
   int checks_done = 0;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, a, e); end end

   always #25 clk = ~clk;

   lii_top #(.FLASH_HALF(4)) u_lii_top (
      .clk(clk), .rst_b(rst_b), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp), .trig_pin(trig_pin),
      .led_ack_pin(ackv[7:0]), .clear_key_pin(ackv[8]),
      .global_indicator_clear_input(ackv[9]), .prot_alarm_pin(ackv[10]),
      .boot_done_pin(boot), .int_fault_pin(fault), .led_red(led_red),
      .led_green(led_green), .health_green(health_green), .self_supervision_relay(relay));

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic int comb(int i);
      int v;
      v = 0;
      for (int s = 0; s < 5; s++) begin
         if (mcfg[i][4*s +: 4] != 0) begin
            v |= trig_pin[mcfg[i][4*s +: 4] - 1] ^ mcfg[i][20+s];
         end
      end
      return v;
   endfunction

   function automatic logic latching(int i);
      return mcfg[i][26:25] == MODE_LATCH || mcfg[i][26:25] == MODE_LATCH_ALARM;
   endfunction

   task automatic ack(logic [7:0] m);
      for (int i = 0; i < 8; i++) begin
         if (m[i] && comb(i) == 0) mlat[i] = 1'b0;
      end
   endtask

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic hang();
      mismatches++;
      end_of_test();
   endtask

   task automatic wr(logic [31:0] a, logic [31:0] d, logic [1:0] e);
      logic aw, w, b, bq;
      logic [1:0] r;
      int n;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(negedge clk);
         aw = awvalid && awready;
         w = wvalid && wready;
         b = bvalid && bready;
         bq = bvalid;
         r = bresp;
         @(posedge clk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (b) break;
         if (bq) bready <= 1'b1;
      end
      bready <= 1'b0;
      if (n == 40) hang();
      `CHK(r, e)
   endtask

   task automatic rd(logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar, v, h;
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(negedge clk);
         ar = arvalid && arready;
         v = rvalid;
         h = rvalid && rready;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ar) arvalid <= 1'b0;
         if (h) break;
         if (v) rready <= 1'b1;
      end
      rready <= 1'b0;
      if (n == 40) hang();
   endtask

   task automatic settle();
      repeat (6) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         if (latching(i) && comb(i) != 0) mlat[i] = 1'b1;
         if (!latching(i) || mcfg[i][19:0] == 0) mlat[i] = 1'b0;
      end
   endtask

   task automatic pulse(logic [10:0] m);
      ackv <= m;
      repeat (3) @(posedge clk);
      ackv <= '0;
   endtask

   task automatic chk(string nm);
      logic [7:0] o_r, o_g, a_r, a_g, s;
      logic oh, ah;
      logic [31:0] d;
      logic [1:0] r;
      logic [2:0] a;
      settle();
      {o_r, o_g, oh} = '0;
      {a_r, a_g, ah} = '1;
      repeat (12) begin
         @(negedge clk);
         {o_r, o_g, oh} = {o_r, o_g, oh} | {led_red, led_green, health_green};
         {a_r, a_g, ah} = {a_r, a_g, ah} & {led_red, led_green, health_green};
      end
      @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         s[i] = comb(i) != 0 || (latching(i) && mlat[i]);
         a = s[i] ? mapp[i][2:0] : mapp[i][5:3];
         `CHK({o_r[i], a_r[i]}, (a == APP_RED) ? 2'h3 : {a == APP_RED_FLASH, 1'b0})
         `CHK({o_g[i], a_g[i]}, (a == APP_GREEN) ? 2'h3 : {a == APP_GREEN_FLASH, 1'b0})
      end
      `CHK({oh, ah}, {1'b1, boot})
      rd(STAT_ADDR, d, r);
      `CHK(d[17:0], {boot & ~fault, boot, mlat, s})
      $display("Test %s done", nm);
   endtask

   task automatic relatch();
      trig_pin <= 15'h00ff;
      settle();
      trig_pin <= 15'h0000;
      chk("relatch");
   endtask

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      {awvalid, wvalid, bready, arvalid, rready, boot, fault} = '0;
      {awaddr, wdata, araddr, trig_pin, ackv, mlat} = '0;
      for (int i = 0; i < 8; i++) begin
         mcfg[i] = '0;
         mapp[i] = '0;
      end
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(CTRL_ADDR, d, r);
      `CHK(d, CTRL_RST)
      rd(32'h0000_0080, d, r);
      `CHK({r, d}, {RESP_SLVERR, 32'h0})
      wr(32'h0000_0080, 32'h1, RESP_SLVERR);
      chk("reset");
      for (int k = 0; k < 6; k++) begin
         for (int i = 0; i < 8; i++) begin
            mcfg[i] = rnd() & 32'h01ff_ffff | ((k & 1) ? 32'h0600_0000 : 32'h0);
            mapp[i] = rnd() & 32'h38 | ((i + k) % 8);
            wr(CFG_BASE + 4 * i, mcfg[i], RESP_OKAY);
            wr(APP_BASE + 4 * i, mapp[i], RESP_OKAY);
         end
         d = rnd();
         trig_pin <= d[14:0];
         chk("combine");
      end
      rd(TRIG_ADDR, d, r);
      `CHK(d, {17'h0, trig_pin})
      trig_pin <= '0;
      settle();
      for (int i = 0; i < 8; i++) begin
         mcfg[i] = ((i == 4 || i == 5) ? 32'h0400_0000 : 32'h0200_0000) | (i + 1);
         mapp[i] = 32'h0a;
         wr(CFG_BASE + 4 * i, mcfg[i], RESP_OKAY);
         wr(APP_BASE + 4 * i, mapp[i], RESP_OKAY);
      end
      relatch();
      trig_pin <= 15'h0001;
      chk("hold");
      pulse(11'h003);
      ack(8'h03);
      chk("own ack");
      pulse(11'h200);
      chk("global blocked");
      pulse(11'h400);
      ack(8'h30);
      chk("alarm");
      wr(CTRL_ADDR, 32'h1, RESP_OKAY);
      pulse(11'h200);
      ack(8'hff);
      chk("global");
      relatch();
      wr(CTRL_ADDR, 32'h3, RESP_OKAY);
      ack(8'hff);
      chk("remote");
      wr(CTRL_ADDR, 32'h0, RESP_OKAY);
      relatch();
      wr(CTRL_ADDR, 32'h2, RESP_OKAY);
      chk("remote blocked");
      pulse(11'h100);
      ack(8'hff);
      chk("key");
      relatch();
      mcfg[2] = 32'h3;
      mcfg[3] = 32'h0200_0000;
      wr(CFG_BASE + 8, mcfg[2], RESP_OKAY);
      wr(CFG_BASE + 12, mcfg[3], RESP_OKAY);
      chk("unlatch");
      boot <= 1'b1;
      chk("boot");
      fault <= 1'b1;
      chk("fault");
      end_of_test();
   end
endmodule
